// *** rtl/cc_port_pkg.sv ***
// constants, state codes and register map for the type-c source port control
// assumes a single 250 MHz clock; times are turned into cycle counts here
package cc_port_pkg;

    // clock period and documented times
    localparam longint unsigned CLK_PERIOD_PS = 64'd4000;
    localparam longint unsigned PROBE_TIME_NS = 64'd50000;
    localparam longint unsigned COOL_TIME_S = 64'd16;
    localparam longint unsigned OC_DEGLITCH_MS = 64'd2;

    // least times, rounded up to whole cycles
    localparam longint unsigned PROBE_CYC =
        (PROBE_TIME_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
    localparam longint unsigned COOL_CYC =
        (COOL_TIME_S * 64'd1000000000000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
    localparam longint unsigned OC_DEGLITCH_CYC =
        (OC_DEGLITCH_MS * 64'd1000000000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;

    // comparator bundle width into the synchroniser
    localparam int SYNC_W = 20;

    // apb register map, byte addresses
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;

    // control register fields and reset value
    localparam int CTRL_PORT_EN_BIT = 0;
    localparam int CTRL_THERM_EN_BIT = 1;
    localparam int CTRL_FORCE_SHED_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h3;

    // port state, gray along probe -> unattached -> attached
    typedef enum logic [2:0] {
        ST_PROBE = 3'h0,
        ST_UNATT = 3'h1,
        ST_ATT = 3'h3,
        ST_ACC = 3'h2,
        ST_TYPEA = 3'h6
    } port_state_t;

endpackage

// *** rtl/cmp_sync.sv ***
// two-flop synchroniser for a bundle of analog comparator results
// assumes each bit is an independent level; no bus coherence is kept
`timescale 1ns/100ps
module cmp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// *** rtl/typec_source_cc_thermal_shed.sv ***
// type-c source port control: attach, vconn, accessories, type-a probe, shedding
// assumes comparator inputs come straight from analog; an apb master drives the bus
//
// What this block does
// - pull-ups on both cc lines; rd on either line means a sink attached
// - default advertisement is 3a through the 4.7k pull-up
// - vbus off while unattached; vbus and vconn on once a sink seen
// - vconn goes to the cc line that shows the ra pull-down
// - ra on both or rd on both: accessory, port output stays off
// - keep watching rd; on detach drop vbus, vconn, return to unattached
// - thermistor above 50 percent selects 12.7k pull-up, 1.5a advertisement
// - while shedding rd is 0.4v to 1.6v, ra below 0.4v
// - shedding disables line drop compensation; feedback adjust keeps running
// - thermistor down to 24 percent restores 3a and 4.7k
// - thermistor at 70 percent opens switch, fault low; back on at 60
// - start-up thermistor 50-70 starts in 1.5a; above 70 stays off, faulted
// - shedding also entered when die temperature exceeds 145 c
// - temperature shedding ends after 16 s continuously below 105 c
// - switch die above 165 c opens switch, cc logic runs; on below 145
// - probe first cc line 50 us, window hit selects type-a mode
// - type-a held to power cycle: no cc logic, vbus on, type-a limit
// - fault low on oc, ov, short, overtemp; only oc has 2 ms deglitch
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module typec_source_cc_thermal_shed
    import cc_port_pkg::*;
#(
    parameter logic [31:0] PROBE_CYCLES = 32'(PROBE_CYC),
    parameter logic [31:0] COOL_CYCLES = 32'(COOL_CYC),
    parameter logic [31:0] OC_DEGLITCH_CYCLES = 32'(OC_DEGLITCH_CYC)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cc comparators, index 0 is the first cc line
    input wire logic [1:0] cc_below_open,
    input wire logic [1:0] cc_below_ra,
    input wire logic [1:0] cc_below_1v6,
    input wire logic [1:0] cc_below_0v4,
    input wire logic cc_typea_window,
    // thermistor comparators against the aux supply
    input wire logic thermistor_sense_in_above_50,
    input wire logic thermistor_sense_in_below_24,
    input wire logic thermistor_sense_in_above_70,
    input wire logic thermistor_sense_in_below_60,
    // temperature comparators
    input wire logic die_above_145,
    input wire logic die_below_105,
    input wire logic switch_above_165,
    input wire logic switch_below_145,
    // fault sources
    input wire logic over_current,
    input wire logic over_voltage,
    input wire logic short_to_battery,
    // cc drive
    output logic [1:0] rp_enable,
    output logic rp_sel_1a5,
    output logic typea_probe_en,
    output logic [1:0] vconn_enable,
    // power path
    output logic vbus_switch_en,
    output logic typea_current_limit,
    output logic ldc_disable,
    output logic feedback_adjust_out_en,
    // open-drain fault pin
    input wire logic fault_out_n_i,
    output logic fault_out_n_o,
    output logic fault_out_n_oe
);

    // level with hysteresis: set wins over clear
    function automatic logic hyst(input logic flag, input logic set, input logic clr);
        hyst = set | (flag & ~clr);
    endfunction

    // synchronised comparator levels
    logic [SYNC_W-1:0] raw_vec;
    logic [SYNC_W-1:0] sync_vec;
    logic [1:0] s_open;
    logic [1:0] s_ra;
    logic [1:0] s_1v6;
    logic [1:0] s_0v4;
    logic s_window;
    logic s_t50;
    logic s_t24;
    logic s_t70;
    logic s_t60;
    logic s_d145;
    logic s_d105;
    logic s_w165;
    logic s_w145;
    logic s_oc;
    logic s_ov;
    logic s_stb;

    // state and flags
    port_state_t state;
    port_state_t next_state;
    logic [2:0] ctrl;
    logic typea_latched;
    logic therm_shed;
    logic temp_shed;
    logic therm_off;
    logic tsd;
    logic [31:0] probe_cnt;
    logic [31:0] cool_cnt;
    logic [31:0] oc_cnt;
    logic [31:0] status_word;

    // decode wires
    wire port_en = ctrl[CTRL_PORT_EN_BIT];
    wire therm_en = ctrl[CTRL_THERM_EN_BIT];
    wire shed = therm_shed | temp_shed | ctrl[CTRL_FORCE_SHED_BIT];
    wire probe_done = (probe_cnt == PROBE_CYCLES - 32'd1);
    wire cool_done = (cool_cnt == COOL_CYCLES);
    wire oc_fault = (oc_cnt == OC_DEGLITCH_CYCLES);
    wire [1:0] rd_norm = s_open & ~s_ra;
    wire [1:0] rd_shed = s_1v6 & ~s_0v4;
    wire [1:0] cc_rd;
    wire [1:0] cc_ra;
    wire sink_seen = |cc_rd;
    wire accessory = (&cc_rd) | (&cc_ra);
    wire [1:0] vconn_pick;
    wire power_ok = port_en & ~therm_off & ~tsd;
    wire fault_active = oc_fault | s_ov | s_stb | therm_off | tsd;

    assign raw_vec = {cc_below_open, cc_below_ra, cc_below_1v6, cc_below_0v4,
                      cc_typea_window, thermistor_sense_in_above_50,
                      thermistor_sense_in_below_24, thermistor_sense_in_above_70,
                      thermistor_sense_in_below_60, die_above_145, die_below_105,
                      switch_above_165, switch_below_145, over_current,
                      over_voltage, short_to_battery};

    cmp_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(raw_vec),
        .sync_out(sync_vec)
    );

    assign {s_open, s_ra, s_1v6, s_0v4, s_window, s_t50, s_t24, s_t70, s_t60,
            s_d145, s_d105, s_w165, s_w145, s_oc, s_ov, s_stb} = sync_vec;

    assign cc_rd = shed ? rd_shed : rd_norm;
    assign cc_ra = shed ? s_0v4 : s_ra;

    assign vconn_pick = cc_ra[1] ? 2'h2 : (cc_ra[0] ? 2'h1 : 2'h0);

    // apb handshake: zero wait, unmapped offsets answer with an error
    wire apb_access = psel & penable;
    wire hit_ctrl = (paddr == CTRL_OFF);
    wire hit_status = (paddr == STATUS_OFF);
    wire ctrl_wr = apb_access & pwrite & hit_ctrl & pstrb[0];
    assign pready = 1'b1;
    assign pslverr = apb_access & ~(hit_ctrl | hit_status);

    // status snapshot of the port's own state
    assign status_word = {16'h0000, vconn_enable, cc_ra, cc_rd, fault_out_n_i,
                          fault_active, typea_latched, tsd, therm_off,
                          temp_shed, therm_shed, state};

    // port state sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_PROBE: begin
                if (probe_done) begin
                    next_state = s_window ? ST_TYPEA : ST_UNATT;
                end
            end
            ST_UNATT: begin
                if (accessory) begin
                    next_state = ST_ACC;
                end else if (sink_seen) begin
                    next_state = ST_ATT;
                end
            end
            ST_ATT: begin
                if (!sink_seen) begin
                    next_state = ST_UNATT;
                end else if (accessory) begin
                    next_state = ST_ACC;
                end
            end
            ST_ACC: begin
                if (!accessory) begin
                    next_state = ST_UNATT;
                end
            end
            ST_TYPEA: begin
                next_state = ST_TYPEA;
            end
            default: begin
                next_state = ST_PROBE;
            end
        endcase
    end

    // state and start-up probe timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_PROBE;
            probe_cnt <= 32'h0;
        end else begin
            state <= next_state;
            if (state == ST_PROBE && !probe_done) begin
                probe_cnt <= probe_cnt + 32'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            typea_latched <= 1'b0;
        end else if (state == ST_PROBE && probe_done && s_window) begin
            typea_latched <= 1'b1;
        end
    end

    // thermistor flags; run from reset so start-up level counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            therm_shed <= 1'b0;
            therm_off <= 1'b0;
        end else begin
            // enter at 50, leave at 24, start-up too
            // a low or floating sense never sets the flag
            therm_shed <= therm_en & hyst(therm_shed, s_t50, s_t24);
            // switch off at 70, back at 60
            therm_off <= therm_en & hyst(therm_off, s_t70, s_t60);
        end
    end

    // die temperature shedding with long cool-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_shed <= 1'b0;
            cool_cnt <= 32'h0;
        end else begin
            temp_shed <= hyst(temp_shed, s_d145, cool_done);
            // 16 s continuous below 105 c; any gap restarts
            if (!temp_shed || !s_d105 || s_d145) begin
                cool_cnt <= 32'h0;
            end else if (!cool_done) begin
                cool_cnt <= cool_cnt + 32'd1;
            end
        end
    end

    // switch thermal shutdown; cc logic is untouched by it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsd <= 1'b0;
        end else begin
            // off above 165, on below 145
            tsd <= hyst(tsd, s_w165, s_w145);
        end
    end

    // over-current deglitch; saturates so a long fault stays flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_cnt <= 32'h0;
        end else if (!s_oc) begin
            oc_cnt <= 32'h0;
        end else if (!oc_fault) begin
            oc_cnt <= oc_cnt + 32'd1;
        end
    end

    // cc termination drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rp_enable <= 2'h0;
            rp_sel_1a5 <= 1'b0;
            typea_probe_en <= 1'b0;
        end else begin
            // pull-ups on both lines outside probe and type-a
            rp_enable <= (next_state == ST_PROBE || next_state == ST_TYPEA) ? 2'h0 : 2'h3;
            rp_sel_1a5 <= shed;
            typea_probe_en <= (next_state == ST_PROBE);
        end
    end

    // power path; vconn follows attach and the port enable only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_switch_en <= 1'b0;
            vconn_enable <= 2'h0;
            typea_current_limit <= 1'b0;
        end else begin
            // vbus only when attached, or type-a
            vbus_switch_en <= power_ok & (next_state == ST_ATT || next_state == ST_TYPEA);
            // vconn on attach while the port is enabled, not gated by therm_off or tsd; dropped on detach
            vconn_enable <= (port_en && next_state == ST_ATT) ? vconn_pick : 2'h0;
            typea_current_limit <= (next_state == ST_TYPEA);
        end
    end

    // compensation and feedback adjust
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ldc_disable <= 1'b0;
            feedback_adjust_out_en <= 1'b0;
        end else begin
            // no line drop compensation while shedding
            ldc_disable <= shed;
            // adjust output never gated by shedding
            feedback_adjust_out_en <= 1'b1;
        end
    end

    // fault pin pulled low while any fault stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_out_n_oe <= 1'b0;
        end else begin
            fault_out_n_oe <= fault_active;
        end
    end

    // open drain: only ever drives low
    assign fault_out_n_o = 1'b0;

    // control register write; software can hold the port off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= pwdata[2:0];
        end
    end

    // read data captured in the setup cycle, ready for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            if (paddr == CTRL_OFF) begin
                prdata <= {29'h0, ctrl};
            end else if (paddr == STATUS_OFF) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h0;
            end
        end
    end

endmodule

// *** tb/cc_port_props.sv ***
// assertions on the port-control outputs against comparator and fault inputs
// assumes one pclk domain; inputs reach the logic through two sync flops
`timescale 1ns/100ps
module cc_port_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // comparators and faults
    input wire logic [1:0] cc_below_open,
    input wire logic [1:0] cc_below_ra,
    input wire logic thermistor_sense_in_above_50,
    input wire logic thermistor_sense_in_above_70,
    input wire logic die_above_145,
    input wire logic switch_above_165,
    input wire logic over_voltage,
    input wire logic short_to_battery,
    // watched outputs
    input wire logic [1:0] vconn_enable,
    input wire logic rp_sel_1a5,
    input wire logic vbus_switch_en,
    input wire logic typea_current_limit,
    input wire logic ldc_disable,
    input wire logic feedback_adjust_out_en,
    input wire logic fault_out_n_oe
);
    // five cycles cover sync flops, state update and output register
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    idle_power_off_a: assert property (
        (cc_below_open == 2'b00 && !typea_current_limit) [*5] |->
        !vbus_switch_en && vconn_enable == 2'b00)
        else $error("port powered with no termination");
    accessory_off_a: assert property (
        (cc_below_open == 2'b11 && (cc_below_ra == 2'b00 || cc_below_ra == 2'b11)
        && !rp_sel_1a5 && !typea_current_limit) [*5] |-> !vbus_switch_en)
        else $error("accessory got vbus");
    vconn_side_a: assert property (
        (cc_below_open == 2'b11 && cc_below_ra == 2'b10 && !rp_sel_1a5
        && !fault_out_n_oe && !typea_current_limit) [*5] |-> vconn_enable == 2'b10)
        else $error("vconn on wrong line");
    therm_trip_a: assert property (
        thermistor_sense_in_above_70 [*5] |-> fault_out_n_oe && !vbus_switch_en)
        else $error("thermistor trip missed");
    switch_hot_a: assert property (
        switch_above_165 [*5] |-> fault_out_n_oe && !vbus_switch_en)
        else $error("switch shutdown missed");
    ov_fault_a: assert property (
        (over_voltage || short_to_battery) [*5] |-> fault_out_n_oe)
        else $error("fault pin not pulled");
    therm_shed_a: assert property (
        thermistor_sense_in_above_50 [*5] |-> rp_sel_1a5 && ldc_disable)
        else $error("thermistor shedding missed");
    die_shed_a: assert property (
        die_above_145 [*5] |-> rp_sel_1a5 && ldc_disable)
        else $error("die shedding missed");
    adjust_alive_a: assert property (
        $past(presetn) |-> feedback_adjust_out_en)
        else $error("feedback adjust dropped");
    typea_hold_a: assert property (
        typea_current_limit |=> typea_current_limit)
        else $error("type-a mode left");
endmodule

bind typec_source_cc_thermal_shed cc_port_props props_u (
    .pclk(pclk), .presetn(presetn), .cc_below_open(cc_below_open),
    .cc_below_ra(cc_below_ra), .thermistor_sense_in_above_50(thermistor_sense_in_above_50),
    .thermistor_sense_in_above_70(thermistor_sense_in_above_70),
    .die_above_145(die_above_145), .switch_above_165(switch_above_165),
    .over_voltage(over_voltage), .short_to_battery(short_to_battery),
    .vconn_enable(vconn_enable), .rp_sel_1a5(rp_sel_1a5), .vbus_switch_en(vbus_switch_en),
    .typea_current_limit(typea_current_limit), .ldc_disable(ldc_disable),
    .feedback_adjust_out_en(feedback_adjust_out_en), .fault_out_n_oe(fault_out_n_oe));

// *** tb/cc_sink_model.sv ***
// sink, cable or accessory seen through the cc comparators
// assumes codes from the bench: 0 open, 1 rd, 2 ra, 3 type-a resistor
`timescale 1ns/100ps
module cc_sink_model (
    // termination per cc line
    input wire logic [1:0] term0,
    input wire logic [1:0] term1,
    // probe current from the port
    input wire logic typea_probe_en,
    // comparator results
    output logic [1:0] cc_below_open,
    output logic [1:0] cc_below_ra,
    output logic [1:0] cc_below_1v6,
    output logic [1:0] cc_below_0v4,
    output logic cc_typea_window
);
    // rd lies inside both threshold pairs, ra below both low ones
    wire logic [1:0] is_rd = {term1 == 2'h1, term0 == 2'h1};
    wire logic [1:0] is_ra = {term1 == 2'h2, term0 == 2'h2};
    assign cc_below_open = is_rd | is_ra;
    assign cc_below_1v6 = is_rd | is_ra;
    assign cc_below_ra = is_ra;
    assign cc_below_0v4 = is_ra;
    assign cc_typea_window = typea_probe_en && term0 == 2'h3;
endmodule

// *** tb/testbench.sv ***
// self-checking bench: apb access plus cc, thermal and fault sequences
// assumes shortened probe, cool-down and deglitch counts set below
`timescale 1ns/100ps
module testbench;
    import cc_port_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pslverr, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [1:0] term0, term1, below_open, below_ra, below_1v6, below_0v4;
    logic [1:0] rp_enable, vconn_enable;
    logic window, probe_en, a50, b24, a70, b60, d145, d105, s165, s145, oc, ov, stb, e;
    logic rp_sel, vbus, typea_lim, ldc, feedback_adjust_out, flt_o, flt_oe;
    int error_cnt = 0;
    int num_checks = 0;

    always #2 pclk = ~pclk;

    // pulled-up open-drain fault pin
    wire logic flt_pin = flt_oe ? flt_o : 1'b1;

    typec_source_cc_thermal_shed #(.PROBE_CYCLES(32'd8), .COOL_CYCLES(32'd20),
        .OC_DEGLITCH_CYCLES(32'd10)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cc_below_open(below_open), .cc_below_ra(below_ra),
        .cc_below_1v6(below_1v6), .cc_below_0v4(below_0v4), .cc_typea_window(window),
        .thermistor_sense_in_above_50(a50), .thermistor_sense_in_below_24(b24),
        .thermistor_sense_in_above_70(a70), .thermistor_sense_in_below_60(b60),
        .die_above_145(d145), .die_below_105(d105), .switch_above_165(s165),
        .switch_below_145(s145), .over_current(oc), .over_voltage(ov),
        .short_to_battery(stb), .rp_enable(rp_enable), .rp_sel_1a5(rp_sel),
        .typea_probe_en(probe_en), .vconn_enable(vconn_enable), .vbus_switch_en(vbus),
        .typea_current_limit(typea_lim), .ldc_disable(ldc),
        .feedback_adjust_out_en(feedback_adjust_out), .fault_out_n_i(flt_pin), .fault_out_n_o(flt_o),
        .fault_out_n_oe(flt_oe));

    cc_sink_model sink_u (.term0(term0), .term1(term1), .typea_probe_en(probe_en),
        .cc_below_open(below_open), .cc_below_ra(below_ra), .cc_below_1v6(below_1v6),
        .cc_below_0v4(below_0v4), .cc_typea_window(window));

    task end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // vbus, vconn[1:0], 1.5a select, fault drive
    task look(input logic [4:0] exp);
        check({27'h0, vbus, vconn_enable, rp_sel, flt_oe}, {27'h0, exp});
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; an extra edge keeps back-to-back calls race free
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                end_sim();
            end
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task set_cc(input logic [1:0] a, input logic [1:0] b);
        term0 <= a;
        term1 <= b;
        cyc(6);
    endtask

    task do_reset(input logic [1:0] t0);
        presetn <= 1'b0;
        term0 <= t0;
        term1 <= 2'h0;
        cyc(6);
        presetn <= 1'b1;
        cyc(2);
        check({31'h0, probe_en}, 32'h1);
        cyc(14);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        pstrb <= 4'hf;
        // thermistor held low: shedding off until driven
        {a50, b24, a70, b60, d145, d105, s165, s145, oc, ov, stb} <= '0;
        do_reset(2'h0);
        apb(1'b0, STATUS_OFF, 32'h0);
        check(q & 32'h7, 32'h1);
        apb(1'b0, CTRL_OFF, 32'h0);
        check(q, 32'h3);
        // a write without the low byte strobe must leave control alone
        pstrb <= 4'he;
        apb(1'b1, CTRL_OFF, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, CTRL_OFF, 32'h0);
        check(q, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        check({q[30:0], e}, 32'h1);
        apb(1'b1, CTRL_OFF, 32'h7);
        cyc(2);
        check({30'h0, rp_sel, ldc}, 32'h3);
        apb(1'b1, CTRL_OFF, 32'h3);
        set_cc(2'h1, 2'h2);
        look(5'b1_10_0_0);
        check({30'h0, rp_enable}, 32'h3);
        set_cc(2'h2, 2'h1);
        look(5'b1_01_0_0);
        set_cc(2'h1, 2'h1);
        look(5'b0_00_0_0);
        set_cc(2'h2, 2'h2);
        look(5'b0_00_0_0);
        set_cc(2'h1, 2'h0);
        look(5'b1_00_0_0);
        // port disabled by software drops vbus while the sink stays
        apb(1'b1, CTRL_OFF, 32'h2);
        cyc(2);
        look(5'b0_00_0_0);
        apb(1'b1, CTRL_OFF, 32'h3);
        set_cc(2'h0, 2'h0);
        look(5'b0_00_0_0);
        a50 <= 1'b1;
        set_cc(2'h0, 2'h1);
        look(5'b1_00_1_0);
        check({30'h0, ldc, feedback_adjust_out}, 32'h3);
        a50 <= 1'b0;
        b24 <= 1'b1;
        cyc(6);
        look(5'b1_00_0_0);
        {a50, a70, b24} <= 3'b110;
        cyc(6);
        look(5'b0_00_1_1);
        {a70, b60} <= 2'b01;
        cyc(6);
        look(5'b1_00_1_0);
        {a50, b60, b24} <= 3'b001;
        s165 <= 1'b1;
        cyc(6);
        look(5'b0_00_0_1);
        apb(1'b0, STATUS_OFF, 32'h0);
        check(q & 32'h7, 32'h3);
        {b24, s165, s145} <= 3'b001;
        cyc(6);
        look(5'b1_00_0_0);
        {s145, d145} <= 2'b01;
        cyc(6);
        look(5'b1_00_1_0);
        {d145, d105} <= 2'b01;
        cyc(12);
        look(5'b1_00_1_0);
        cyc(20);
        look(5'b1_00_0_0);
        d105 <= 1'b0;
        // over-voltage and short each pull the pin at once
        for (int i = 0; i < 2; i++) begin
            {ov, stb} <= i[0] ? 2'b01 : 2'b10;
            cyc(5);
            check({31'h0, flt_pin}, 32'h0);
            {ov, stb} <= 2'b00;
            cyc(4);
        end
        oc <= 1'b1;
        cyc(6);
        look(5'b1_00_0_0);
        cyc(12);
        look(5'b1_00_0_1);
        oc <= 1'b0;
        // hot thermistor before start-up: begin in the 1.5a advertisement
        a50 <= 1'b1;
        do_reset(2'h3);
        check({30'h0, typea_lim, vbus}, 32'h3);
        check({30'h0, rp_sel, ldc}, 32'h3);
        set_cc(2'h1, 2'h1);
        check({30'h0, typea_lim, vbus}, 32'h3);
        end_sim();
    end
endmodule
